// File: adc_conversion_control.sv
// Purpose: conversion sequencing, trigger selection and status for the converter
// Assumes: sample_data and compare_match come from the analog side on this clock
// Notes: register read data stand for one cycle after the read strobe
//
// Summary of operation
// - single mode, software: one conversion per write
// - single mode, hardware: one conversion per trigger
// - queue enabled: each trigger runs one set
// - continuous bit makes conversions repeat endlessly
// - continuous with queue loops the whole set
// - five-bit field selects the converted channel
// - active flag set on start, cleared on end
// - trigger select bit picks software or hardware
// - compare enable bit switches compare function
// - no interrupt while interrupt enable is clear
// - interrupt asserted when done sets with enable
// - first register write aborts, restarts in software single mode unless all-ones
// - done flag per conversion or set, cleared
// - queue starts when filled under software trigger; all-ones resets it
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic hw_trigger_input,
  input wire logic [9:0] sample_data,
  input wire logic compare_match,
  output logic conv_start,
  output logic [4:0] conv_channel,
  output logic conversion_active_flag,
  output logic compare_enable,
  output logic compare_greater,
  output logic irq
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic conversion_done_flag;
  logic complete_irq_enable;
  logic continuous_mode_bit;
  logic [4:0] channel_select_field;
  logic trigger_select_bit;
  logic compare_enable_bit;
  logic compare_greater_bit;
  logic [2:0] queue_depth_field;
  logic [9:0] result;
  logic result_unread;

  // channel queue
  logic [4:0] chan_queue [QUEUE_ENTRIES];
  logic [2:0] q_count;
  logic [2:0] q_pos;
  conv_state_t state;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic wr_one;
  logic wr_two;
  logic wr_four;
  logic rd_low;
  logic queue_on;
  logic q_full;
  logic wr_stop;
  logic [2:0] wr_index;
  logic fill_complete;

  assign wr_one = wr_en && (addr == ADDR_SC1);
  assign wr_two = wr_en && (addr == ADDR_SC2);
  assign wr_four = wr_en && (addr == ADDR_SC4);
  assign rd_low = rd_en && (addr == ADDR_RL);
  assign queue_on = (queue_depth_field != 3'h0);
  assign q_full = queue_on && (q_count == queue_depth_field);
  assign wr_stop = (wr_data[4:0] == CHAN_OFF);
  // a write to a full queue begins a new fill at entry 0
  assign wr_index = q_full ? 3'h0 : q_count;
  assign fill_complete = queue_on && ((wr_index + 3'h1) == queue_depth_field);

  // ---------------------------------------------------------------
  // hardware trigger synchroniser
  // ---------------------------------------------------------------
  logic hw_s1;
  logic hw_s2;
  logic hw_s3;
  logic hw_level;
  logic hw_edge;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hw_s1 <= 1'b0;
      hw_s2 <= 1'b0;
      hw_s3 <= 1'b0;
      hw_level <= 1'b0;
    end
    else
    begin
      hw_s1 <= hw_trigger_input;
      hw_s2 <= hw_s1;
      hw_s3 <= hw_s2;
      if (hw_s2 == hw_s3)
      begin
        hw_level <= hw_s3;
      end
    end
  end

  assign hw_edge = (hw_s2 == hw_s3) && hw_s3 && !hw_level;

  // ---------------------------------------------------------------
  // conversion timer
  // ---------------------------------------------------------------
  logic start_now;
  logic abort_now;
  logic conv_done;

  conv_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(start_now),
    .abort(abort_now),
    .busy(),
    .done(conv_done)
  );

  // ---------------------------------------------------------------
  // sequencing decisions
  // ---------------------------------------------------------------
  logic [4:0] start_chan;
  logic [2:0] next_q_pos;
  logic set_end;
  conv_state_t next_state;

  always_comb
  begin
    start_now = 1'b0;
    abort_now = 1'b0;
    start_chan = channel_select_field;
    next_q_pos = q_pos;
    set_end = 1'b0;
    next_state = state;
    if (wr_one)
    begin
      // every write to the first register ends what is running
      abort_now = 1'b1;
      next_state = st_idle;
      if (!trigger_select_bit && !wr_stop)
      begin
        if (!queue_on)
        begin
          start_now = 1'b1;
          start_chan = wr_data[4:0];
        end
        else if (fill_complete)
        begin
          start_now = 1'b1;
          start_chan = (wr_index == 3'h0) ? wr_data[4:0] : chan_queue[0];
          next_q_pos = 3'h0;
        end
      end
    end
    else if (hw_edge && trigger_select_bit && (state == st_idle))
    begin
      if (!queue_on && (channel_select_field != CHAN_OFF))
      begin
        start_now = 1'b1;
        start_chan = channel_select_field;
      end
      else if (q_full)
      begin
        start_now = 1'b1;
        start_chan = chan_queue[0];
        next_q_pos = 3'h0;
      end
    end
    else if (conv_done && (state == st_conv))
    begin
      if (queue_on && ((q_pos + 3'h1) < queue_depth_field))
      begin
        start_now = 1'b1;
        next_q_pos = q_pos + 3'h1;
        start_chan = chan_queue[next_q_pos];
      end
      else
      begin
        set_end = 1'b1;
        if (continuous_mode_bit)
        begin
          start_now = 1'b1;
          next_q_pos = 3'h0;
          start_chan = queue_on ? chan_queue[0] : channel_select_field;
        end
        else
        begin
          next_state = st_idle;
        end
      end
    end
    if (start_now)
    begin
      next_state = st_conv;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= st_idle;
      q_pos <= 3'h0;
      conv_start <= 1'b0;
      conv_channel <= CHAN_RESET;
      conversion_active_flag <= 1'b0;
    end
    else
    begin
      state <= next_state;
      q_pos <= next_q_pos;
      conv_start <= start_now;
      conversion_active_flag <= (next_state == st_conv);
      if (start_now)
      begin
        conv_channel <= start_chan;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel queue fill
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q_count <= 3'h0;
    end
    else if (wr_four)
    begin
      q_count <= 3'h0;
    end
    else if (wr_one && queue_on)
    begin
      if (wr_stop)
      begin
        q_count <= 3'h0;
      end
      else
      begin
        q_count <= wr_index + 3'h1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < QUEUE_ENTRIES; gi = gi + 1)
    begin : g_queue
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          chan_queue[gi] <= CHAN_RESET;
        end
        else if (wr_one && queue_on && !wr_stop && (wr_index == 3'(gi)))
        begin
          chan_queue[gi] <= wr_data[4:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      complete_irq_enable <= 1'b0;
      continuous_mode_bit <= 1'b0;
      channel_select_field <= CHAN_RESET;
    end
    else if (wr_one)
    begin
      complete_irq_enable <= wr_data[SC1_IRQ_EN];
      continuous_mode_bit <= wr_data[SC1_CONT];
      channel_select_field <= wr_data[4:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      trigger_select_bit <= 1'b0;
      compare_enable_bit <= 1'b0;
      compare_greater_bit <= 1'b0;
    end
    else if (wr_two)
    begin
      trigger_select_bit <= wr_data[SC2_TRIG];
      compare_enable_bit <= wr_data[SC2_CMP_EN];
      compare_greater_bit <= wr_data[SC2_CMP_GT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      queue_depth_field <= DEPTH_RESET;
    end
    else if (wr_four)
    begin
      queue_depth_field <= wr_data[2:0];
    end
  end

  assign compare_enable = compare_enable_bit;
  assign compare_greater = compare_greater_bit;

  // ---------------------------------------------------------------
  // done flag, result and interrupt
  // ---------------------------------------------------------------
  logic set_done;
  logic next_done;
  logic next_irq_en;

  // with compare on, only a matching result completes
  assign set_done = set_end && (!compare_enable_bit || compare_match);
  assign next_done = set_done ? 1'b1 : ((wr_one || rd_low) ? 1'b0 : conversion_done_flag);
  assign next_irq_en = wr_one ? wr_data[SC1_IRQ_EN] : complete_irq_enable;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      conversion_done_flag <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      conversion_done_flag <= next_done;
      irq <= next_done && next_irq_en;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      result <= RESULT_RESET;
      result_unread <= 1'b0;
    end
    else
    begin
      if (conv_done && (state == st_conv))
      begin
        result <= sample_data;
        result_unread <= 1'b1;
      end
      else if (rd_low)
      begin
        result_unread <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_data <= 8'h00;
    end
    else if (rd_en)
    begin
      case (addr)
        ADDR_SC1: rd_data <= {conversion_done_flag, complete_irq_enable,
                              continuous_mode_bit, channel_select_field};
        ADDR_SC2: rd_data <= {conversion_active_flag, trigger_select_bit, compare_enable_bit,
                              compare_greater_bit, !result_unread, result_unread, 2'b00};
        ADDR_SC4: rd_data <= {5'h00, queue_depth_field};
        ADDR_RH: rd_data <= {6'h00, result[9:8]};
        ADDR_RL: rd_data <= result[7:0];
        default: rd_data <= 8'h00;
      endcase
    end
    else
    begin
      rd_data <= 8'h00;
    end
  end

endmodule : adc_conversion_control

// File: adc_conversion_control_checker.sv
// Purpose: port-level assertions for the converter control block
// Assumes: trigger, enable and depth are shadowed from bus writes
// Notes: attached by the bind at the foot
`timescale 1ns/1ns
module adc_conversion_control_checker
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic hw_trigger_input,
  input wire logic [9:0] sample_data,
  input wire logic compare_match,
  input wire logic conv_start,
  input wire logic [4:0] conv_channel,
  input wire logic conversion_active_flag,
  input wire logic compare_enable,
  input wire logic compare_greater,
  input wire logic irq
);
  localparam int PERIOD = CONV_CYCLES + 1;
  logic trig_q;
  logic ien_q;
  logic [2:0] depth_q;
  logic [7:0] cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----
  // shadows and start counter
  // ----
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      trig_q <= 1'b0;
      ien_q <= 1'b0;
      depth_q <= 3'h0;
    end
    else if (wr_en)
    begin
      if (addr == ADDR_SC2)
        trig_q <= wr_data[SC2_TRIG];
      if (addr == ADDR_SC1)
        ien_q <= wr_data[SC1_IRQ_EN];
      if (addr == ADDR_SC4)
        depth_q <= wr_data[2:0];
    end
  end

  // cycles since the latest start, saturating
  always_ff @(posedge clk)
  begin
    if (sys_rst || conv_start)
      cnt <= {7'h00, conv_start};
    else if (cnt != 8'hff)
      cnt <= cnt + 8'h01;
  end

  sequence s_sw_go;
    wr_en && addr == ADDR_SC1 && wr_data[4:0] != CHAN_OFF && !trig_q && depth_q == 3'h0;
  endsequence
  sequence s_stop;
    wr_en && addr == ADDR_SC1 && wr_data[4:0] == CHAN_OFF;
  endsequence
  sequence s_set_end;
    $fell(conversion_active_flag) && !$past(wr_en);
  endsequence

  a_sw_write_start: assert property (
    s_sw_go |=> conv_start && conv_channel == $past(wr_data[4:0]))
    else $error("write did not start its channel");
  a_all_ones_stop: assert property (
    s_stop |=> !conversion_active_flag && !conv_start)
    else $error("all-ones write did not stop");
  a_hw_no_start: assert property (
    wr_en && addr == ADDR_SC1 && trig_q |=> !conv_start)
    else $error("write started under hw trigger");
  a_start_active: assert property (
    conv_start |-> conversion_active_flag)
    else $error("start without active flag");
  a_end_length: assert property (
    s_set_end |-> cnt == PERIOD)
    else $error("active flag fell at wrong time");
  a_repeat_period: assert property (
    conv_start && $past(conversion_active_flag) && !$past(wr_en) |-> cnt == PERIOD)
    else $error("repeat start at wrong spacing");
  a_done_irq: assert property (
    s_set_end ##0 (ien_q && !compare_enable) |-> ##[0:1] irq)
    else $error("no interrupt at end");
  a_irq_gated: assert property (
    !ien_q && !$past(ien_q) |-> !irq)
    else $error("interrupt while disabled");
  a_cmp_follow: assert property (
    wr_en && addr == ADDR_SC2 |=> compare_enable == $past(wr_data[SC2_CMP_EN]))
    else $error("compare enable not updated");
endmodule : adc_conversion_control_checker

bind adc_conversion_control adc_conversion_control_checker adc_conversion_control_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .hw_trigger_input(hw_trigger_input),
  .sample_data(sample_data), .compare_match(compare_match), .conv_start(conv_start),
  .conv_channel(conv_channel), .conversion_active_flag(conversion_active_flag),
  .compare_enable(compare_enable), .compare_greater(compare_greater), .irq(irq));

// File: adc_ctrl_pkg.sv
// Purpose: shared constants and types for the converter control logic
// Assumes: byte address is four times the register index, 8-bit data in the low lane
// Notes: one conversion is modelled as a fixed count of clock cycles
package adc_ctrl_pkg;

  // ---------------------------------------------------------------
  // clock and conversion timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CONV_TIME_NS = 160;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] CONV_CNT_LAST = 5'(CONV_CYCLES - 1);

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_SC1 = 8'h10;
  localparam logic [7:0] IDX_SC2 = 8'h11;
  localparam logic [7:0] IDX_SC4 = 8'h13;
  localparam logic [7:0] IDX_RH = 8'h14;
  localparam logic [7:0] IDX_RL = 8'h15;
  localparam logic [7:0] ADDR_SC1 = {IDX_SC1[5:0], 2'b00};
  localparam logic [7:0] ADDR_SC2 = {IDX_SC2[5:0], 2'b00};
  localparam logic [7:0] ADDR_SC4 = {IDX_SC4[5:0], 2'b00};
  localparam logic [7:0] ADDR_RH = {IDX_RH[5:0], 2'b00};
  localparam logic [7:0] ADDR_RL = {IDX_RL[5:0], 2'b00};

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned SC1_DONE = 7;
  localparam int unsigned SC1_IRQ_EN = 6;
  localparam int unsigned SC1_CONT = 5;
  localparam int unsigned SC2_ACTIVE = 7;
  localparam int unsigned SC2_TRIG = 6;
  localparam int unsigned SC2_CMP_EN = 5;
  localparam int unsigned SC2_CMP_GT = 4;
  localparam int unsigned SC2_EMPTY = 3;
  localparam int unsigned SC2_FULL = 2;
  localparam int unsigned CHAN_W = 5;
  localparam int unsigned DEPTH_W = 3;
  localparam int unsigned QUEUE_ENTRIES = 8;
  localparam int unsigned RESULT_W = 10;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  localparam logic [4:0] CHAN_RESET = 5'h1f;
  localparam logic [2:0] DEPTH_RESET = 3'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_conv = 1'b1
  } conv_state_t;

endpackage : adc_ctrl_pkg

// File: analog_side_model.sv
// Purpose: stand-in for the analog converter beside the block
// Assumes: result and compare outcome come back on the block clock
// Notes: result carries the converted channel so captures can be checked
`timescale 1ns/1ns
module analog_side_model
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] conv_channel,
  input wire logic match_ok,
  output logic [9:0] sample_data,
  output logic compare_match
);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sample_data <= RESULT_RESET;
      compare_match <= 1'b0;
    end
    else
    begin
      sample_data <= {conv_channel, 5'h15};
      compare_match <= match_ok;
    end
  end
endmodule : analog_side_model

// File: conv_timer.sv
// Purpose: times one conversion and pulses done at its end
// Assumes: start and abort come from logic on the same clock
// Notes: start wins over abort so an abort-and-restart is one cycle
`timescale 1ns/1ns
module conv_timer
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);

  logic [4:0] cnt;

  // ---------------------------------------------------------------
  // cycle counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt <= 5'h00;
        busy <= 1'b1;
      end
      else if (abort)
      begin
        busy <= 1'b0;
      end
      else if (busy)
      begin
        if (cnt == CONV_CNT_LAST)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          cnt <= cnt + 5'h01;
        end
      end
    end
  end

endmodule : conv_timer

// File: tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: analog side from its model, trigger pin from here
// Notes: seeded random channels mixed with fixed corner cases
`timescale 1ns/1ns
module tb
  import adc_ctrl_pkg::*;
;
  logic clk, sys_rst, wr_en, rd_en, hw_trigger_input, match_ok, ie, compare_match;
  logic conv_start, conversion_active_flag, compare_enable, compare_greater, irq;
  logic [7:0] addr, wr_data, rd_data;
  logic [9:0] sample_data;
  logic [4:0] conv_channel, ch;
  logic [4:0] chq[$];
  int n_mismatch, n_tests, n_start, n0, seed;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  adc_conversion_control adc_conversion_control_inst (.clk(clk), .sys_rst(sys_rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .hw_trigger_input(hw_trigger_input), .sample_data(sample_data),
    .compare_match(compare_match), .conv_start(conv_start), .conv_channel(conv_channel),
    .conversion_active_flag(conversion_active_flag), .compare_enable(compare_enable),
    .compare_greater(compare_greater), .irq(irq));
  analog_side_model analog_side_model_inst (.clk(clk), .sys_rst(sys_rst),
    .conv_channel(conv_channel), .match_ok(match_ok), .sample_data(sample_data),
    .compare_match(compare_match));

  // ----
  // bus and check tasks
  // ----
  always @(posedge clk)
    if (conv_start)
    begin
      n_start <= n_start + 1;
      chq.push_back(conv_channel);
    end

  function automatic logic [7:0] exp_sc1(input logic en, input logic [4:0] c, input logic d);
    return {d, en, 1'b0, c};
  endfunction : exp_sc1

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %0d starts", $time, got);
    end
  endtask : chk_cnt

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk_val(rd_data, exp);
  endtask : rdc

  // write, wait, then count the starts seen meanwhile
  task automatic run(input logic [7:0] a, input logic [7:0] d, input int n, input int lo,
    input int hi);
    n0 = n_start;
    wr(a, d);
    idle(n);
    chk_cnt(n_start - n0, lo, hi);
  endtask : run

  task automatic pulse(input int lo);
    n0 = n_start;
    @(posedge clk);
    hw_trigger_input <= 1'b1;
    idle(3);
    hw_trigger_input <= 1'b0;
    idle(30);
    chk_cnt(n_start - n0, lo, lo);
  endtask : pulse

  task automatic halt();
    wr(ADDR_SC1, 8'h1f);
    #1;
    chk_val(8'(conversion_active_flag), 8'h00);
  endtask : halt

  task automatic print_verdict();
    $display("tests %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    seed = 32'hc039;
    sys_rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    hw_trigger_input = 1'b0;
    match_ok = 1'b1;
    idle(5);
    sys_rst <= 1'b0;
    rdc(ADDR_SC1, 8'h1f);
    rdc(ADDR_SC2, 8'h08);
    rdc(8'h7c, 8'h00);
    repeat (4)
    begin
      ch = 5'($unsigned($random(seed)) % 31);
      ie = 1'($random(seed));
      run(ADDR_SC1, exp_sc1(ie, ch, 1'b0), 30, 1, 1);
      chk_val(8'(chq[$]), 8'(ch));
      chk_val(8'(irq), 8'(ie));
      rdc(ADDR_SC1, exp_sc1(ie, ch, 1'b1));
      rdc(ADDR_RL, {ch[2:0], 5'h15});
      rdc(ADDR_SC1, exp_sc1(ie, ch, 1'b0));
    end
    run(ADDR_SC1, 8'h04, 5, 1, 1);
    chk_val(8'(conversion_active_flag), 8'h01);
    run(ADDR_SC1, 8'h06, 30, 1, 1);
    chk_val(8'(chq[$]), 8'h06);
    run(ADDR_SC1, 8'h07, 5, 1, 1);
    halt();
    run(ADDR_SC1, 8'h25, 70, 3, 4);
    halt();
    wr(ADDR_SC2, 8'h40);
    run(ADDR_SC1, 8'h03, 25, 0, 0);
    pulse(1);
    wr(ADDR_SC2, 8'h00);
    pulse(0);
    wr(ADDR_SC2, 8'h30);
    #1;
    chk_val(8'(compare_greater), 8'h01);
    chk_val(8'(compare_enable), 8'h01);
    match_ok <= 1'b0;
    run(ADDR_SC1, 8'h42, 30, 1, 1);
    chk_val(8'(irq), 8'h00);
    match_ok <= 1'b1;
    run(ADDR_SC1, 8'h42, 30, 1, 1);
    chk_val(8'(irq), 8'h01);
    wr(ADDR_SC2, 8'h00);
    wr(ADDR_SC4, 8'h02);
    run(ADDR_SC1, 8'h01, 10, 0, 0);
    run(ADDR_SC1, 8'h02, 50, 2, 2);
    chk_val(8'(chq[$ - 1]), 8'h01);
    halt();
    wr(ADDR_SC1, 8'h21);
    run(ADDR_SC1, 8'h22, 90, 4, 5);
    halt();
    // hardware trigger runs a full queued set
    wr(ADDR_SC2, 8'h40);
    wr(ADDR_SC1, 8'h01);
    wr(ADDR_SC1, 8'h02);
    pulse(2);
    chk_val(8'(chq[$]), 8'h02);
    rdc(ADDR_SC4, 8'h02);
    wr(ADDR_SC4, 8'h00);
    // hardware trigger with continuous mode repeats
    wr(ADDR_SC2, 8'h60);
    wr(ADDR_SC1, 8'h65);
    pulse(2);
    chk_val(8'(chq[$]), 8'h05);
    // reset in mid-run must clear the modes
    @(posedge clk);
    sys_rst <= 1'b1;
    idle(5);
    sys_rst <= 1'b0;
    rdc(ADDR_SC1, 8'h1f);
    rdc(ADDR_SC2, 8'h08);
    print_verdict();
  end
endmodule : tb
